// ### dv/iifs_top_props.sv
`timescale 1ns/1ps
module iifs_top_props
  import iifs_pkg::*;
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // flag side
  input wire logic [16:0] hw_flag_set,
  input wire logic        tx_buffer_written,
  input wire logic [16:0] flags
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  sequence b_wait; s_axi_bvalid && !s_axi_bready; endsequence
  sequence r_wait; s_axi_rvalid && !s_axi_rready; endsequence
  flags_reset_a: assert property ($rose(aresetn) |-> flags == IIFS_FLAG_RST) else $error("bad flag reset");
  wr_answer_a: assert property (wr_take |=> s_axi_bvalid) else $error("no write answer");
  b_hold_a: assert property (b_wait |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  b_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("ready in resp");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
  r_hold_a: assert property (r_wait |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
  hw_set_a: assert property (|hw_flag_set |-> ##2 ((flags & $past(hw_flag_set, 2)) == $past(hw_flag_set, 2)))
    else $error("hw set lost");
  tx_clear_a: assert property (tx_buffer_written && !hw_flag_set[4] |-> ##2 !flags[4])
    else $error("tx level kept");
endmodule
bind iifs_top iifs_top_props u_iifs_top_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .hw_flag_set, .tx_buffer_written, .flags);

// ### dv/tb_iifs_top.sv
`timescale 1ns/1ps
`define CMP(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tb_iifs_top
  import iifs_pkg::*;
;
  logic        aclk, aresetn;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_val;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [16:0] hw_flag_set, flags, bit_m;
  logic        tx_buffer_written, rx_buffer_read, rx_buffer_has_data;
  int          error_cnt, checks, cyc;

  iifs_top u_iifs_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .hw_flag_set, .tx_buffer_written, .rx_buffer_read, .rx_buffer_has_data, .flags);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic summarize();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd_val = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  // one cycle of flag events, then settle
  task automatic ev(input logic [16:0] h, input logic t, input logic r, input logic v);
    @(posedge aclk);
    hw_flag_set <= h;
    tx_buffer_written <= t;
    rx_buffer_read <= r;
    rx_buffer_has_data <= v;
    @(posedge aclk);
    hw_flag_set <= '0;
    tx_buffer_written <= 1'b0;
    rx_buffer_read <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask

  // look at the flag port away from the edge that launches it
  task automatic cf(input logic [16:0] e);
    @(negedge aclk);
    `CMP(flags, e)
    @(posedge aclk);
  endtask

  initial begin
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata, hw_flag_set} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {tx_buffer_written, rx_buffer_read, rx_buffer_has_data} = '0;
    s_axi_wstrb = 4'hF;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    cf(17'h00010);
    rd(IIFS_OFF_SET);
    `CMP(rd_val, 32'h00000000)
    // every settable flag, set then cleared
    for (int b = 0; b < 17; b++) begin
      if (b != 4 && b != 5) begin
        bit_m = 17'h00001 << b;
        wr(IIFS_OFF_SET, {15'h0000, bit_m});
        `CMP(resp, IIFS_RESP_OKAY)
        rd(IIFS_OFF_FLAG);
        `CMP(rd_val, {15'h0, bit_m | 17'h10})
        wr(IIFS_OFF_CLEAR, {15'h0000, bit_m});
        cf(17'h00010);
      end
    end
    // all byte lanes off: nothing lands
    s_axi_wstrb <= 4'h0;
    wr(IIFS_OFF_SET, 32'h0001FFCF);
    s_axi_wstrb <= 4'hF;
    cf(17'h00010);
    // status register takes no writes
    wr(IIFS_OFF_FLAG, 32'h0001FFCF);
    `CMP(resp, IIFS_RESP_OKAY)
    cf(17'h00010);
    wr(IIFS_OFF_SET, 32'h0001FFCF);
    wr(IIFS_OFF_SET, 32'h00000000);
    cf(17'h1FFDF);
    rd(IIFS_OFF_SET);
    `CMP(rd_val, 32'h00000000)
    wr(IIFS_OFF_CLEAR, 32'h0001FFCF);
    cf(17'h00010);
    // unmapped place
    wr(8'h40, 32'h00000001);
    `CMP(resp, IIFS_RESP_SLVERR)
    rd(8'h40);
    `CMP(resp, IIFS_RESP_SLVERR)
    ev(17'h00001, 1'b1, 1'b0, 1'b1);
    cf(17'h00021);
    ev(17'h00010, 1'b0, 1'b1, 1'b0);
    cf(17'h00011);
    // second reset mid-run
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    cf(17'h00010);
    summarize();
  end
endmodule

// ### rtl/iifs_flag_bank.sv
`timescale 1ns/1ps
module iifs_flag_bank
  import iifs_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // flag traffic
  iifs_flag_if.bank fb
);
  logic [16:0] flags;
  logic [16:0] next_flags;
  logic [16:0] sw_set;

  assign sw_set = fb.set_mask & IIFS_W1_MASK;

  genvar gi;
  generate
    for (gi = 0; gi < IIFS_NFLAGS; gi++) begin : g_flag
      if (gi == IIFS_B_TX_LEVEL) begin : g_txlvl
        // set on empty wins over clear on write
        assign next_flags[gi] = fb.hw_set[gi] ? 1'b1 : (fb.tx_written ? 1'b0 : flags[gi]);
      end else if (gi == IIFS_B_RXV) begin : g_rxv
        // follows buffer fill, dropped by a read
        assign next_flags[gi] = fb.hw_set[gi] | (fb.rx_has_data & ~fb.rx_read);
      end else begin : g_evt
        // set from either source beats clear
        assign next_flags[gi] = fb.hw_set[gi] | sw_set[gi] | (flags[gi] & ~fb.clr_mask[gi]);
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= IIFS_FLAG_RST;
    end else begin
      flags <= next_flags;
    end
  end

  assign fb.flags = flags;
endmodule

// ### rtl/iifs_flag_if.sv
`timescale 1ns/1ps
interface iifs_flag_if;
  logic [16:0] set_mask;
  logic [16:0] clr_mask;
  logic [16:0] hw_set;
  logic        tx_written;
  logic        rx_read;
  logic        rx_has_data;
  logic [16:0] flags;
  modport bank (input set_mask, clr_mask, hw_set, tx_written, rx_read, rx_has_data, output flags);
  modport ctrl (output set_mask, clr_mask, hw_set, tx_written, rx_read, rx_has_data, input flags);
endinterface

// ### rtl/iifs_pkg.sv
package iifs_pkg;
  localparam int unsigned IIFS_DATA_W = 32;
  localparam int unsigned IIFS_ADDR_W = 8;
  // register byte offsets
  localparam logic [7:0] IIFS_OFF_FLAG  = 8'h28;
  localparam logic [7:0] IIFS_OFF_SET   = 8'h2C;
  localparam logic [7:0] IIFS_OFF_CLEAR = 8'h30;
  // flag bit positions
  localparam int unsigned IIFS_B_START      = 0;
  localparam int unsigned IIFS_B_REPSTART   = 1;
  localparam int unsigned IIFS_B_ADDR       = 2;
  localparam int unsigned IIFS_B_TXDONE     = 3;
  localparam int unsigned IIFS_B_TX_LEVEL   = 4;
  localparam int unsigned IIFS_B_RXV        = 5;
  localparam int unsigned IIFS_B_ACK        = 6;
  localparam int unsigned IIFS_B_NACK       = 7;
  localparam int unsigned IIFS_B_CSTOP      = 8;
  localparam int unsigned IIFS_B_ARB        = 9;
  localparam int unsigned IIFS_B_BUSFAULT   = 10;
  localparam int unsigned IIFS_B_BUSHELD    = 11;
  localparam int unsigned IIFS_B_TX_OVF     = 12;
  localparam int unsigned IIFS_B_RX_UNF     = 13;
  localparam int unsigned IIFS_B_IDLE_TO    = 14;
  localparam int unsigned IIFS_B_LOW_TO     = 15;
  localparam int unsigned IIFS_B_TSTOP      = 16;
  localparam int unsigned IIFS_NFLAGS       = 17;
  // bits that the set and clear registers reach
  localparam logic [16:0] IIFS_W1_MASK = 17'h1FFCF;
  // value after reset of the flag register
  localparam logic [16:0] IIFS_FLAG_RST = 17'h00010;
  localparam logic [1:0]  IIFS_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  IIFS_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    IIFS_W_IDLE = 2'b01,
    IIFS_W_RESP = 2'b10
  } iifs_wstate_t;
endpackage

// ### rtl/iifs_top.sv
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
// What this block does
// - set register at 0x02C, resets zero
// - bit 16 sets target stop flag
// - bit 15 sets clock low timeout
// - bit 14 sets bus idle timeout
// - bit 13 sets rx underflow flag
// - bit 12 sets tx overflow flag
// - bit 11 sets bus held flag
// - bit 10 sets bus fault flag
// - bit 9 sets arbitration lost flag
// - bit 8 sets controller stop sent
// - bit 7 sets nack received flag
// - bit 6 sets ack received flag
// - bit 3 sets transfer done flag
// - bit 2 sets address match flag
// - bit 1 sets repeated start flag
// - bit 0 sets start flag
// - tx level flag: reset one, auto clear
// - rx valid follows buffer, clears on read
// - clear register at 0x030 clears flags 16..6 and 3..0
module iifs_top
  import iifs_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // hardware flag events, one-cycle pulses; rx_buffer_has_data is a level
  input  wire logic [16:0] hw_flag_set,
  input  wire logic        tx_buffer_written,
  input  wire logic        rx_buffer_read,
  input  wire logic        rx_buffer_has_data,
  // flag state
  output logic [16:0]      flags
);
  iifs_flag_if fbus ();

  iifs_wstate_t wstate;
  iifs_wstate_t next_wstate;
  logic         aw_held;
  logic         w_held;
  logic [7:0]   aw_addr;
  logic [31:0]  w_data;
  logic [3:0]   w_strb;
  logic [31:0]  set_pulse;
  logic [31:0]  clr_pulse;

  // write channel
  wire        aw_take   = s_axi_awvalid & s_axi_awready;
  wire        w_take    = s_axi_wvalid & s_axi_wready;
  wire        have_aw   = aw_held | aw_take;
  wire        have_w    = w_held | w_take;
  wire [7:0]  cur_waddr = aw_take ? s_axi_awaddr : aw_addr;
  wire [31:0] cur_wdata = w_take ? s_axi_wdata : w_data;
  wire [3:0]  cur_wstrb = w_take ? s_axi_wstrb : w_strb;
  wire        do_write  = (wstate == IIFS_W_IDLE) & have_aw & have_w;
  wire [7:0]  waddr_al  = {cur_waddr[7:2], 2'b00};
  wire        hit_set   = waddr_al == IIFS_OFF_SET;
  wire        hit_clr   = waddr_al == IIFS_OFF_CLEAR;
  wire        hit_flag  = waddr_al == IIFS_OFF_FLAG;
  wire        w_mapped  = hit_set | hit_clr | hit_flag;

  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // ones only act, reserved bits dropped
  wire [31:0] w1_bits    = cur_wdata & strb_mask(cur_wstrb) & {15'h0000, IIFS_W1_MASK};
  wire [31:0] next_set   = (do_write & hit_set) ? w1_bits : 32'h00000000;
  wire [31:0] next_clr   = (do_write & hit_clr) ? w1_bits : 32'h00000000;

  always_comb begin
    next_wstate = wstate;
    case (wstate)
      IIFS_W_IDLE: begin
        if (do_write) begin
          next_wstate = IIFS_W_RESP;
        end
      end
      IIFS_W_RESP: begin
        if (s_axi_bready) begin
          next_wstate = IIFS_W_IDLE;
        end
      end
      default: next_wstate = IIFS_W_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate        <= IIFS_W_IDLE;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= IIFS_RESP_OKAY;
      set_pulse     <= 32'h00000000;
      clr_pulse     <= 32'h00000000;
    end else begin
      wstate        <= next_wstate;
      set_pulse     <= next_set;
      clr_pulse     <= next_clr;
      if (aw_take) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      aw_held       <= do_write ? 1'b0 : have_aw;
      w_held        <= do_write ? 1'b0 : have_w;
      s_axi_awready <= (next_wstate == IIFS_W_IDLE) & ~(do_write ? 1'b0 : have_aw);
      s_axi_wready  <= (next_wstate == IIFS_W_IDLE) & ~(do_write ? 1'b0 : have_w);
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= w_mapped ? IIFS_RESP_OKAY : IIFS_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel
  wire        ar_take   = s_axi_arvalid & s_axi_arready;
  wire [7:0]  raddr_al  = {s_axi_araddr[7:2], 2'b00};
  wire        r_flag    = raddr_al == IIFS_OFF_FLAG;
  wire        r_w1      = (raddr_al == IIFS_OFF_SET) | (raddr_al == IIFS_OFF_CLEAR);
  // set and clear registers read as zero
  wire [31:0] rd_value  = r_flag ? {15'h0000, fbus.flags} : 32'h00000000;
  wire [1:0]  rd_resp   = (r_flag | r_w1) ? IIFS_RESP_OKAY : IIFS_RESP_SLVERR;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= IIFS_RESP_OKAY;
    end else begin
      if (ar_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_value;
        s_axi_rresp   <= rd_resp;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // software set bits 16..6 and 3..0 reach the flags
  assign fbus.set_mask    = set_pulse[16:0];
  assign fbus.clr_mask    = clr_pulse[16:0];
  assign fbus.hw_set      = hw_flag_set;
  assign fbus.tx_written  = tx_buffer_written;
  assign fbus.rx_read     = rx_buffer_read;
  assign fbus.rx_has_data = rx_buffer_has_data;

  iifs_flag_bank u_bank (
    .aclk    (aclk),
    .aresetn (aresetn),
    .fb      (fbus.bank)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= IIFS_FLAG_RST;
    end else begin
      flags <= fbus.flags;
    end
  end
endmodule
